/* ebap_pkg.sv */
// Constants, timing counts and state type for the byte-wide memory host controller
// What this block does
// - Select low, output drive high, write strobe low writes the data byte.
// - Host keeps write strobe high at least 9.9 ms before the next write.
// - Chip erase: select and strobe low, output drive at high voltage, data all ones.
// - Host holds write strobe low at least 10 ms during chip erase.
package ebap_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 18;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    localparam logic [1:0] CMD_READ  = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_ERASE = 2'h2;

    localparam logic [DATA_W-1:0] ERASE_DATA = 8'hFF;
    localparam int                POLL_BIT   = 7;

    // ------------------------------------------------------------------
    // Times in ns and their cycle counts
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int ACCESS_NS         = 250;
    localparam int SYNC_CYC          = 2;
    localparam int FLOAT_NS          = 80;
    localparam int WE_PULSE_NS       = 150;
    localparam int DATA_HOLD_NS      = 20;
    localparam int ERASE_SETUP_NS    = 500;
    localparam int ERASE_CE_HOLD_NS  = 5000;
    localparam int ERASE_OE_EXTRA_NS = 3000;
    localparam int ERASE_STROBE_NS   = 10000000;
    localparam int POST_WE_HIGH_NS   = 9900000;

    localparam int READ_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;
    localparam int FLOAT_CYC   = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC      = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DH_CYC      = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ESETUP_CYC  = (ERASE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ECH_CYC     = (ERASE_CE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOEH_CYC    = (ERASE_OE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EWP_CYC     = (ERASE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WEH_CYC     = (POST_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_WR_ADDR,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_POLL,
        ST_ER_SETUP,
        ST_ER_PULSE,
        ST_ER_HOLD,
        ST_ER_RELEASE
    } ebap_state_t;

endpackage

/* ebap_tmr_if.sv */
// Carrier between the host sequencer and its write recovery timer
`timescale 1ns/1ps
interface ebap_tmr_if;
    logic                        start;    // Load and run the timer
    logic [ebap_pkg::CNT_W-1:0]  load;     // Cycles to wait
    logic                        expired;  // Timer at zero

    modport owner (output start, output load, input expired);
    modport timer (input start, input load, output expired);
endinterface

/* ebap_timer.sv */
// Down counter that guards the quiet time after each write
`timescale 1ns/1ps
module ebap_timer (
    input  wire logic  clk,    // System clock
    input  wire logic  rst_n,  // Synchronised reset, active low
    ebap_tmr_if.timer  tmr     // Start, load and expiry
);

    logic [ebap_pkg::CNT_W-1:0] count_reg;
    logic [ebap_pkg::CNT_W-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (tmr.start) begin
            count_next = tmr.load;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign tmr.expired = (count_reg == '0);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_quiet_after_start;
        @(posedge clk) disable iff (!rst_n)
        (tmr.start && tmr.load > 18'h00002) |=> !tmr.expired [*2];
    endproperty
    a_quiet_after_start: assert property (p_quiet_after_start)
        else $error("Write recovery timer expired too early");

endmodule

/* ebap_host.sv */
// Host controller driving the byte-wide electrically erasable memory pins
`timescale 1ns/1ps
module ebap_host #(
    parameter int EWP_CYC = ebap_pkg::EWP_CYC,  // Erase strobe width in cycles
    parameter int WEH_CYC = ebap_pkg::WEH_CYC   // Strobe high time after a write
) (
    input  wire logic                        SYS_CLK,     // 20 MHz clock
    input  wire logic                        RESET_N,     // Async reset, active low
    input  wire logic                        REQ_VALID,   // Request present
    output logic                             REQ_READY,   // Request taken this cycle
    input  wire logic [1:0]                  REQ_CMD,     // Read, write or erase
    input  wire logic [ebap_pkg::ADDR_W-1:0] REQ_ADDR,    // Byte address
    input  wire logic [ebap_pkg::DATA_W-1:0] REQ_WDATA,   // Write byte
    output logic                             RSP_VALID,   // One-cycle completion
    output logic [ebap_pkg::DATA_W-1:0]      RSP_RDATA,   // Read or final poll byte
    output logic                             RSP_TIMEOUT, // Poll never matched
    output logic                             MEM_CE_N,    // Device select, active low
    output logic                             MEM_OE_N,    // Output drive, active low
    output logic                             MEM_ERASE_HV,// Output drive at erase voltage
    output logic                             MEM_WE_N,    // Write strobe, active low
    output logic [ebap_pkg::ADDR_W-1:0]      MEM_ADDR,    // Byte address lines
    output logic [ebap_pkg::DATA_W-1:0]      MEM_DATA_O,  // Data lines, host drive
    output logic                             MEM_DATA_OE, // High while host drives data
    input  wire logic [ebap_pkg::DATA_W-1:0] MEM_DATA_I   // Data lines, sensed
);

    // ------------------------------------------------------------------
    // Reset release and input synchroniser
    // ------------------------------------------------------------------
    logic                         rst_meta_reg;
    logic                         rst_n;
    logic [ebap_pkg::DATA_W-1:0]  din_meta_reg;
    logic [ebap_pkg::DATA_W-1:0]  din_reg;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            din_meta_reg <= 8'h00;
            din_reg      <= 8'h00;
        end else begin
            din_meta_reg <= MEM_DATA_I;
            din_reg      <= din_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Write recovery timer
    // ------------------------------------------------------------------
    ebap_tmr_if tmr ();

    ebap_timer u_timer (
        .clk   (SYS_CLK),
        .rst_n (rst_n),
        .tmr   (tmr.timer)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    ebap_pkg::ebap_state_t               state_reg,  state_next;
    logic [ebap_pkg::CNT_W-1:0]          cnt_reg,    cnt_next;
    logic                                ce_n_reg,   ce_n_next;
    logic                                oe_n_reg,   oe_n_next;
    logic                                we_n_reg,   we_n_next;
    logic                                hv_reg,     hv_next;
    logic                                doe_reg,    doe_next;
    logic [ebap_pkg::ADDR_W-1:0]         addr_reg,   addr_next;
    logic [ebap_pkg::DATA_W-1:0]         dout_reg,   dout_next;
    logic [ebap_pkg::DATA_W-1:0]         rdata_reg,  rdata_next;
    logic                                rsp_reg,    rsp_next;
    logic                                tout_reg,   tout_next;
    logic                                cnt_zero;
    logic                                accept;

    assign cnt_zero  = (cnt_reg == '0);
    // Writes and erases wait out the recovery time of the previous write
    assign REQ_READY = (state_reg == ebap_pkg::ST_IDLE)
                     && (REQ_CMD == ebap_pkg::CMD_READ || tmr.expired);
    assign accept    = REQ_VALID && REQ_READY;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
        ce_n_next  = ce_n_reg;
        oe_n_next  = oe_n_reg;
        we_n_next  = we_n_reg;
        hv_next    = hv_reg;
        doe_next   = doe_reg;
        addr_next  = addr_reg;
        dout_next  = dout_reg;
        rdata_next = rdata_reg;
        rsp_next   = 1'b0;
        tout_next  = 1'b0;
        tmr.start  = 1'b0;
        tmr.load   = ebap_pkg::CNT_W'(WEH_CYC);
        case (state_reg)
            ebap_pkg::ST_IDLE: begin
                if (accept) begin
                    addr_next = REQ_ADDR;
                    if (REQ_CMD == ebap_pkg::CMD_READ) begin
                        ce_n_next  = 1'b0;
                        oe_n_next  = 1'b0;
                        cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::READ_CYC);
                        state_next = ebap_pkg::ST_RD_WAIT;
                    end else if (REQ_CMD == ebap_pkg::CMD_WRITE) begin
                        // Address settles and device output floats before data drive
                        ce_n_next  = 1'b0;
                        oe_n_next  = 1'b1;
                        dout_next  = REQ_WDATA;
                        cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::FLOAT_CYC);
                        state_next = ebap_pkg::ST_WR_ADDR;
                    end else begin
                        hv_next    = 1'b1;
                        oe_n_next  = 1'b1;
                        doe_next   = 1'b1;
                        dout_next  = ebap_pkg::ERASE_DATA;
                        cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::ESETUP_CYC);
                        state_next = ebap_pkg::ST_ER_SETUP;
                    end
                end
            end
            ebap_pkg::ST_RD_WAIT: begin
                if (cnt_zero) begin
                    rdata_next = din_reg;
                    rsp_next   = 1'b1;
                    ce_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    state_next = ebap_pkg::ST_IDLE;
                end
            end
            ebap_pkg::ST_WR_ADDR: begin
                if (cnt_zero) begin
                    we_n_next  = 1'b0;
                    doe_next   = 1'b1;
                    cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::WP_CYC - 1);
                    state_next = ebap_pkg::ST_WR_PULSE;
                end
            end
            ebap_pkg::ST_WR_PULSE: begin
                if (cnt_zero) begin
                    // Strobe rises first so data is latched before it is released
                    we_n_next  = 1'b1;
                    tmr.start  = 1'b1;
                    cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::DH_CYC);
                    state_next = ebap_pkg::ST_WR_HOLD;
                end
            end
            ebap_pkg::ST_WR_HOLD: begin
                if (cnt_zero) begin
                    doe_next   = 1'b0;
                    oe_n_next  = 1'b0;
                    cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::READ_CYC);
                    state_next = ebap_pkg::ST_POLL;
                end
            end
            ebap_pkg::ST_POLL: begin
                if (cnt_zero) begin
                    rdata_next = din_reg;
                    cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::READ_CYC);
                    // Inverted top bit means the internal write is still running
                    if (din_reg[ebap_pkg::POLL_BIT] == dout_reg[ebap_pkg::POLL_BIT]
                        || tmr.expired) begin
                        rsp_next   = 1'b1;
                        tout_next  = din_reg[ebap_pkg::POLL_BIT]
                                     != dout_reg[ebap_pkg::POLL_BIT];
                        ce_n_next  = 1'b1;
                        oe_n_next  = 1'b1;
                        state_next = ebap_pkg::ST_IDLE;
                    end
                end
            end
            ebap_pkg::ST_ER_SETUP: begin
                if (cnt_zero) begin
                    ce_n_next  = 1'b0;
                    we_n_next  = 1'b0;
                    cnt_next   = ebap_pkg::CNT_W'(EWP_CYC - 1);
                    state_next = ebap_pkg::ST_ER_PULSE;
                end
            end
            ebap_pkg::ST_ER_PULSE: begin
                if (cnt_zero) begin
                    we_n_next  = 1'b1;
                    cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::ECH_CYC);
                    state_next = ebap_pkg::ST_ER_HOLD;
                end
            end
            ebap_pkg::ST_ER_HOLD: begin
                if (cnt_zero) begin
                    ce_n_next  = 1'b1;
                    cnt_next   = ebap_pkg::CNT_W'(ebap_pkg::EOEH_CYC);
                    state_next = ebap_pkg::ST_ER_RELEASE;
                end
            end
            ebap_pkg::ST_ER_RELEASE: begin
                if (cnt_zero) begin
                    hv_next    = 1'b0;
                    doe_next   = 1'b0;
                    rsp_next   = 1'b1;
                    state_next = ebap_pkg::ST_IDLE;
                end
            end
            default: begin
                ce_n_next  = 1'b1;
                oe_n_next  = 1'b1;
                we_n_next  = 1'b1;
                hv_next    = 1'b0;
                doe_next   = 1'b0;
                state_next = ebap_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ebap_pkg::ST_IDLE;
            cnt_reg   <= '0;
            ce_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
            hv_reg    <= 1'b0;
            doe_reg   <= 1'b0;
            addr_reg  <= 9'h000;
            dout_reg  <= 8'h00;
            rdata_reg <= 8'h00;
            rsp_reg   <= 1'b0;
            tout_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            ce_n_reg  <= ce_n_next;
            oe_n_reg  <= oe_n_next;
            we_n_reg  <= we_n_next;
            hv_reg    <= hv_next;
            doe_reg   <= doe_next;
            addr_reg  <= addr_next;
            dout_reg  <= dout_next;
            rdata_reg <= rdata_next;
            rsp_reg   <= rsp_next;
            tout_reg  <= tout_next;
        end
    end

    assign MEM_CE_N     = ce_n_reg;
    assign MEM_OE_N     = oe_n_reg;
    assign MEM_WE_N     = we_n_reg;
    assign MEM_ERASE_HV = hv_reg;
    assign MEM_ADDR     = addr_reg;
    assign MEM_DATA_O   = dout_reg;
    assign MEM_DATA_OE  = doe_reg;
    assign RSP_VALID    = rsp_reg;
    assign RSP_RDATA    = rdata_reg;
    assign RSP_TIMEOUT  = tout_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [ebap_pkg::CNT_W-1:0] erase_low_reg;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            erase_low_reg <= '0;
        end else begin
            erase_low_reg <= (hv_reg && !we_n_reg) ? erase_low_reg + 1'b1 : '0;
        end
    end

    sequence s_strobe_low;
        !we_n_reg [*3];
    endsequence

    property p_standby_float;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (ce_n_reg && !hv_reg) |-> (!doe_reg && we_n_reg);
    endproperty
    a_standby_float: assert property (p_standby_float)
        else $error("Data driven or strobe low while deselected");

    property p_read_levels;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (state_reg == ebap_pkg::ST_RD_WAIT) |-> (!ce_n_reg && !oe_n_reg && we_n_reg && !doe_reg);
    endproperty
    a_read_levels: assert property (p_read_levels)
        else $error("Read pin levels wrong");

    property p_write_oe_high;
        @(posedge SYS_CLK) disable iff (!rst_n)
        !we_n_reg |-> (oe_n_reg && !ce_n_reg && doe_reg);
    endproperty
    a_write_oe_high: assert property (p_write_oe_high)
        else $error("Write strobe low without output drive high");

    property p_strobe_width;
        @(posedge SYS_CLK) disable iff (!rst_n)
        $fell(we_n_reg) |-> s_strobe_low;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("Write strobe pulse too short");

    property p_data_at_rise;
        @(posedge SYS_CLK) disable iff (!rst_n)
        ($rose(we_n_reg) && !hv_reg) |-> (doe_reg && $stable(dout_reg) && $stable(addr_reg));
    endproperty
    a_data_at_rise: assert property (p_data_at_rise)
        else $error("Data or address moved at strobe rise");

    property p_addr_stable;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (!ce_n_reg && $past(!ce_n_reg)) |-> $stable(addr_reg);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("Address changed while selected");

    property p_recovery;
        @(posedge SYS_CLK) disable iff (!rst_n)
        $fell(we_n_reg) |-> $past(tmr.expired, 4);
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("Write started before recovery time");

    property p_erase_data;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (hv_reg && !we_n_reg) |-> (!ce_n_reg && doe_reg && dout_reg == ebap_pkg::ERASE_DATA);
    endproperty
    a_erase_data: assert property (p_erase_data)
        else $error("Erase levels wrong");

    property p_erase_width;
        @(posedge SYS_CLK) disable iff (!rst_n)
        ($rose(we_n_reg) && hv_reg) |-> ($past(erase_low_reg) >= ebap_pkg::CNT_W'(EWP_CYC - 1));
    endproperty
    a_erase_width: assert property (p_erase_width)
        else $error("Erase strobe too short");

    property p_poll_match;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (state_reg == ebap_pkg::ST_POLL && rsp_next && !tout_next)
        |=> (RSP_RDATA[7] == dout_reg[7] && RSP_VALID && state_reg == ebap_pkg::ST_IDLE);
    endproperty
    a_poll_match: assert property (p_poll_match)
        else $error("Poll completion without matching top bit");

endmodule

/* ebap_dev_model.sv */
// Behavioural model of the byte-wide erasable memory device
`timescale 1ns/1ps
module ebap_dev_model #(
    parameter int         WRITE_NS = 1000,  // Internal write time
    parameter int         EWP_NS   = 1000,  // Least erase strobe width
    parameter int         WEH_NS   = 2000,  // Least strobe high time between writes
    parameter logic [7:0] ERASED   = 8'hFF  // Value of an erased byte
) (
    input  wire logic       ce_n,     // Device select
    input  wire logic       oe_n,     // Output drive
    input  wire logic       hv,       // Output drive at erase voltage
    input  wire logic       we_n,     // Write strobe
    input  wire logic [8:0] addr,     // Byte address
    input  wire logic [7:0] host_d,   // Host data
    input  wire logic       host_oe,  // Host drives data
    output logic [7:0]      bus,      // Resolved data lines
    output int              faults    // Host breaches seen
);
    logic [7:0] mem [0:511];
    logic [7:0] drv;
    logic [7:0] prev;
    logic [7:0] wd;
    logic [8:0] wa;
    logic [8:0] la;
    logic       busy;
    logic       dev_oe;
    realtime    t_fall;
    realtime    t_rise;
    initial begin
        busy = 1'b0;
        prev = 8'h00;
        faults = 0;
        t_rise = -1.0e9;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    assign dev_oe = !ce_n && !oe_n && we_n && !hv;
    assign drv = host_oe ? host_d
               : (busy && addr == wa) ? {~wd[7], mem[addr][6:0]} : mem[addr];
    // Released lines show the inverse of the last driven value
    always @(drv or host_oe or dev_oe) if (host_oe || dev_oe) prev = drv;
    assign bus = (host_oe || dev_oe) ? drv : ~prev;
    // Settle one step so a swap of drivers on one clock edge is not counted
    always @(host_oe or dev_oe) #1 if (host_oe && dev_oe) faults++;
    always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
        t_fall = $realtime;
        la = addr;
    end
    always @(posedge we_n or posedge ce_n) if (we_n != ce_n) begin
        if ($realtime - t_fall > 20.0) begin
            if (hv) begin
                if ($realtime - t_fall < EWP_NS || host_d !== 8'hFF) faults++;
                else foreach (mem[i]) mem[i] = ERASED;
            end else if (oe_n && !busy) begin
                if (t_fall - t_rise < WEH_NS) faults++;
                t_rise = $realtime;
                wa = la;
                wd = host_d;
                busy = 1'b1;
                #(WRITE_NS) mem[wa] = wd;
                busy = 1'b0;
            end
        end
    end
endmodule

/* test_eeprom_byte_access_port.sv */
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
module test_eeprom_byte_access_port;
    localparam int EWP = 20;
    localparam int WEH = 40;
    logic       SYS_CLK = 1'b0;
    logic       RESET_N = 1'b0;
    logic       REQ_VALID = 1'b0;
    logic [1:0] REQ_CMD = 2'h0;
    logic [8:0] REQ_ADDR = 9'h000;
    logic [7:0] REQ_WDATA = 8'h00;
    logic       REQ_READY, RSP_VALID, RSP_TIMEOUT, MEM_DATA_OE;
    logic       MEM_CE_N, MEM_OE_N, MEM_ERASE_HV, MEM_WE_N;
    logic [7:0] RSP_RDATA, MEM_DATA_O, bus;
    logic [8:0] MEM_ADDR;
    int         mismatches = 0;
    int         comparisons = 0;
    int         faults;
    ebap_host #(.EWP_CYC(EWP), .WEH_CYC(WEH)) ebap_host_i (.SYS_CLK, .RESET_N, .REQ_VALID,
        .REQ_READY, .REQ_CMD, .REQ_ADDR, .REQ_WDATA, .RSP_VALID, .RSP_RDATA, .RSP_TIMEOUT,
        .MEM_CE_N, .MEM_OE_N, .MEM_ERASE_HV, .MEM_WE_N, .MEM_ADDR, .MEM_DATA_O,
        .MEM_DATA_OE, .MEM_DATA_I(bus));
    ebap_dev_model #(.EWP_NS(EWP * 50), .WEH_NS(WEH * 50)) ebap_dev_model_i (.ce_n(MEM_CE_N),
        .oe_n(MEM_OE_N), .hv(MEM_ERASE_HV), .we_n(MEM_WE_N), .addr(MEM_ADDR),
        .host_d(MEM_DATA_O), .host_oe(MEM_DATA_OE), .bus(bus), .faults(faults));
    always #25 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic req(input logic [1:0] cmd, input logic [8:0] a, input logic [7:0] d);
        int n;
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b1;
        REQ_CMD <= cmd;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        n = 0;
        do begin
            @(negedge SYS_CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 2000);
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b0;
        n = 0;
        do begin
            @(negedge SYS_CLK);
            n++;
        end while (RSP_VALID !== 1'b1 && n < 2000);
        chk({7'h00, RSP_VALID}, 8'h01, "no response");
    endtask
    task automatic t_idle();
        @(negedge SYS_CLK);
        chk({3'h0, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_ERASE_HV, MEM_DATA_OE}, 8'h1C, "pins");
    endtask
    task automatic t_write_poll();
        req(2'h1, 9'h1FF, 8'hA5);
        chk(RSP_RDATA, 8'hA5, "poll byte");
        chk({7'h00, RSP_TIMEOUT}, 8'h00, "poll timeout");
        req(2'h0, 9'h1FF, 8'h00);
        chk(RSP_RDATA, 8'hA5, "read top");
    endtask
    task automatic t_back_to_back();
        req(2'h1, 9'h000, 8'h3C);
        chk(RSP_RDATA, 8'h3C, "poll low");
        req(2'h0, 9'h000, 8'h00);
        chk(RSP_RDATA, 8'h3C, "read low");
        req(2'h0, 9'h1FF, 8'h00);
        chk(RSP_RDATA, 8'hA5, "read top kept");
    endtask
    task automatic t_erase();
        req(2'h2, 9'h0AA, 8'h00);
        req(2'h0, 9'h000, 8'h00);
        chk(RSP_RDATA, 8'hFF, "erase low");
        req(2'h0, 9'h1FF, 8'h00);
        chk(RSP_RDATA, 8'hFF, "erase top");
        req(2'h1, 9'h0AA, 8'h5A);
        req(2'h0, 9'h0AA, 8'h00);
        chk(RSP_RDATA, 8'h5A, "write after erase");
        t_idle();
        chk(8'(faults), 8'h00, "device saw a breach");
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        t_idle();
        t_write_poll();
        t_back_to_back();
        t_erase();
        close_out();
    end
    initial begin
        #1000000;
        mismatches++;
        close_out();
    end
endmodule
